// *** rtl/pipp_pkg.sv ***
// Constants, register map and state layout for the port interrupt block
package pipp_pkg;

   // ---------------------------------------------------------------
   // Bus and register map
   // ---------------------------------------------------------------
   localparam int AXI_AW = 16;
   localparam int AXI_DW = 32;
   // Register indices; the byte address is four times the index
   localparam logic [11:0] IDX_PA_PEND = 12'hfc3;
   localparam logic [11:0] IDX_PC_PEND = 12'hfc6;
   localparam logic [11:0] IDX_PRI_HI = 12'hfd0;
   localparam logic [11:0] IDX_PRI_LO = 12'hfd1;
   localparam logic [11:0] IDX_CTRL = 12'hfd2;
   localparam logic [15:0] ADDR_PA_PEND = {2'h0, IDX_PA_PEND, 2'h0};
   localparam logic [15:0] ADDR_PC_PEND = {2'h0, IDX_PC_PEND, 2'h0};
   localparam logic [15:0] ADDR_PRI_HI = {2'h0, IDX_PRI_HI, 2'h0};
   localparam logic [15:0] ADDR_PRI_LO = {2'h0, IDX_PRI_LO, 2'h0};
   localparam logic [15:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Fields and codes
   // ---------------------------------------------------------------
   localparam int PA_N = 8;
   localparam int PC_N = 4;
   localparam int SRC_N = PA_N + PC_N;
   localparam int PA_CMP_BIT = 6;
   localparam int CTRL_GLB_EN_BIT = 0;
   localparam int CTRL_CMP_SEL_BIT = 1;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] PRI_OFF = 2'h0;
   localparam logic [1:0] PRI_LOW = 2'h1;
   localparam logic [1:0] PRI_NOM = 2'h2;
   localparam logic [1:0] PRI_HIGH = 2'h3;
   localparam logic [1:0] PC_FIXED_PRI = PRI_LOW;

   // ---------------------------------------------------------------
   // Whole state of the block
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [PA_N-1:0] pa_pend;
      logic [PC_N-1:0] pc_pend;
      logic [PA_N-1:0] pri_hi;
      logic [PA_N-1:0] pri_lo;
      logic glb_en;
      logic cmp_sel;
      logic awready;
      logic wready;
      logic arready;
      logic aw_full;
      logic [AXI_AW-1:0] awaddr;
      logic w_full;
      logic [7:0] wdata;
      logic wlane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic int_req;
      logic [1:0] int_pri;
      logic [3:0] int_src;
   } state_t;

   localparam state_t RST_STATE = '0;

endpackage

// *** rtl/port_interrupt_pending_priority.sv ***
// Pending capture and priority forwarding of port pin interrupts
//
// How it works
// (R1) A request sets its source's pending bit
// (R2) Pending bits record whether or not globally enabled
// (R3) Global enable forwards pending requests to core
// (R4) Global disable forwards nothing; core polls pending
// (R5) Port A bits 7..0; bit 6 pin or comparator
// (R6) Pending 0 idle, 1 request awaiting service
// (R7) Port C pins 3..0 in bits 3..0
// (R8) Two-bit code from high and low registers
// (R9) 00 off, 01 low, 10 nominal, 11 high
// (R10) Software writes zero upper bits; reset clears pending
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module port_interrupt_pending_priority
   import pipp_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RSTN,
   // Interrupt sources
   input wire logic [PA_N-1:0] PA_REQ,
   input wire logic CMP_REQ,
   input wire logic [PC_N-1:0] PC_REQ,
   // Core side
   input wire logic INT_ACK,
   output logic INT_REQUEST,
   output logic [1:0] INT_PRIORITY,
   output logic [3:0] INT_SOURCE,
   // AXI4-Lite slave
   input wire logic [AXI_AW-1:0] AWADDR,
   input wire logic [2:0] AWPROT,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [AXI_DW-1:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [AXI_AW-1:0] ARADDR,
   input wire logic [2:0] ARPROT,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [AXI_DW-1:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);

   // ---------------------------------------------------------------
   // State and working signals
   // ---------------------------------------------------------------
   state_t q;
   state_t d;
   // Per-source request sets and acknowledge clears
   logic [PA_N-1:0] set_a;
   logic [PC_N-1:0] set_c;
   logic [PA_N-1:0] clr_a;
   logic [PC_N-1:0] clr_c;
   // Priority search
   logic [SRC_N-1:0] pend_v;
   logic [1:0] src_pri [SRC_N];
   logic [1:0] best_pri;
   logic [3:0] best_src;
   // Read decode
   logic [7:0] rd_byte;
   logic rd_hit;

   // ---------------------------------------------------------------
   // Request inputs
   // ---------------------------------------------------------------
   // Bit 6 listens to the pin or to the comparator, never both; the
   // source that is not selected is simply not recorded
   always_comb
   begin
      set_a = PA_REQ; // R5
      set_a[PA_CMP_BIT] = q.cmp_sel ? CMP_REQ : PA_REQ[PA_CMP_BIT]; // R5
      set_c = PC_REQ; // R7
   end

   // ---------------------------------------------------------------
   // Acknowledge decode
   // ---------------------------------------------------------------
   // The acknowledge clears the source that was shown; that source trails
   // the pending bits, so an acknowledge held on may clear a second one
   always_comb
   begin
      clr_a = '0;
      clr_c = '0;
      if (INT_ACK && q.int_req)
      begin
         if (q.int_src < 4'(PA_N))
         begin
            clr_a[q.int_src[2:0]] = 1'b1;
         end
         else
         begin
            clr_c[q.int_src[1:0]] = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Source levels
   // ---------------------------------------------------------------
   // All pending bits side by side, port A low and port C above it
   assign pend_v = {q.pc_pend, q.pa_pend};

   // Port A takes its level from the enable pair; port C has no pair,
   // so it sits at a fixed low level and is always enabled
   for (genvar g = 0; g < SRC_N; g++)
   begin
      if (g < PA_N)
      begin
         assign src_pri[g] = {q.pri_hi[g], q.pri_lo[g]}; // R8 R9
      end
      else
      begin
         assign src_pri[g] = PC_FIXED_PRI;
      end
   end

   // ---------------------------------------------------------------
   // Priority resolution
   // ---------------------------------------------------------------
   // Highest level wins; within a level the lowest index wins, so a busy
   // low-numbered source can starve its higher-numbered peers
   always_comb
   begin
      best_pri = PRI_OFF; // R9
      best_src = 4'h0;
      for (int i = 0; i < SRC_N; i++)
      begin
         if (pend_v[i] && src_pri[i] > best_pri)
         begin
            best_pri = src_pri[i]; // R9
            best_src = 4'(i);
         end
      end
   end

   // ---------------------------------------------------------------
   // Read decode
   // ---------------------------------------------------------------
   // Data comes from the current state, so a write that commits in the
   // same cycle shows on the next read, not on this one
   always_comb
   begin
      rd_hit = 1'b1;
      rd_byte = RST_BYTE;
      case (ARADDR)
         ADDR_PA_PEND: rd_byte = q.pa_pend; // R4
         ADDR_PC_PEND: rd_byte = {4'h0, q.pc_pend}; // R4
         ADDR_PRI_HI: rd_byte = q.pri_hi;
         ADDR_PRI_LO: rd_byte = q.pri_lo;
         ADDR_CTRL:
         begin
            rd_byte[CTRL_GLB_EN_BIT] = q.glb_en;
            rd_byte[CTRL_CMP_SEL_BIT] = q.cmp_sel;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // Register the whole state; reset clears every pending bit
   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         q <= RST_STATE; // R10
      end
      else
      begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      d = q;

      // Write address and data may arrive in either order
      if (AWVALID && q.awready)
      begin
         d.aw_full = 1'b1;
         d.awaddr = AWADDR;
      end
      if (WVALID && q.wready)
      begin
         d.w_full = 1'b1;
         d.wdata = WDATA[7:0];
         d.wlane = WSTRB[0];
      end
      if (BREADY && q.bvalid)
      begin
         d.bvalid = 1'b0;
      end

      // Commit a write once both halves are held
      if (q.aw_full && q.w_full && !q.bvalid)
      begin
         d.aw_full = 1'b0;
         d.w_full = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         case (q.awaddr)
            // Port A pending bits; software may set or clear them
            ADDR_PA_PEND:
            begin
               if (q.wlane)
               begin
                  d.pa_pend = q.wdata;
               end
            end
            ADDR_PC_PEND:
            begin
               // Upper nibble is not stored and reads zero
               if (q.wlane)
               begin
                  d.pc_pend = q.wdata[PC_N-1:0];
               end
            end
            // Upper bits of the level pairs
            ADDR_PRI_HI:
            begin
               if (q.wlane)
               begin
                  d.pri_hi = q.wdata; // R8
               end
            end
            // Lower bits of the level pairs
            ADDR_PRI_LO:
            begin
               if (q.wlane)
               begin
                  d.pri_lo = q.wdata; // R8
               end
            end
            // Global enable and the bit 6 source select
            ADDR_CTRL:
            begin
               if (q.wlane)
               begin
                  d.glb_en = q.wdata[CTRL_GLB_EN_BIT];
                  d.cmp_sel = q.wdata[CTRL_CMP_SEL_BIT];
               end
            end
            // Unmapped: nothing stored, error answer
            default:
            begin
               d.bresp = RESP_SLVERR;
            end
         endcase
      end

      // Acknowledge clears first; a request in the same cycle still wins
      d.pa_pend = (d.pa_pend & ~clr_a) | set_a; // R1 R2 R6
      d.pc_pend = (d.pc_pend & ~clr_c) | set_c; // R1 R2 R6

      // Read answer stands until the master takes it
      if (RREADY && q.rvalid)
      begin
         d.rvalid = 1'b0;
      end
      if (ARVALID && q.arready)
      begin
         d.rvalid = 1'b1;
         d.rdata = rd_byte;
         d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end

      // Forward only while globally enabled; polled mode stays silent.
      // The source is shown even when nothing is forwarded, so the core
      // must read it only together with the request
      d.int_req = q.glb_en && (best_pri != PRI_OFF); // R3 R4
      d.int_pri = q.glb_en ? best_pri : PRI_OFF; // R3 R4
      d.int_src = best_src;

      // Ready flags are registered so the ports come from flops; taking
      // the next state lets a slot reopen the cycle after its answer
      d.awready = !d.aw_full && !d.bvalid;
      d.wready = !d.w_full && !d.bvalid;
      d.arready = !d.rvalid;
   end

   // ---------------------------------------------------------------
   // Outputs, straight from the state flops
   // ---------------------------------------------------------------
   // Request, level and source trail the pending bits by one cycle
   assign INT_REQUEST = q.int_req;
   assign INT_PRIORITY = q.int_pri;
   assign INT_SOURCE = q.int_src;
   assign AWREADY = q.awready;
   assign WREADY = q.wready;
   assign BVALID = q.bvalid;
   assign BRESP = q.bresp;
   assign ARREADY = q.arready;
   assign RVALID = q.rvalid;
   assign RRESP = q.rresp;
   assign RDATA = {24'h000000, q.rdata};

endmodule

// *** verif/pipp_sva.sv ***
// Port checker for the port interrupt block
`timescale 1ns/10ps
module pipp_sva
   import pipp_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic [PA_N-1:0] PA_REQ,
   input wire logic CMP_REQ,
   input wire logic [PC_N-1:0] PC_REQ,
   input wire logic INT_ACK,
   input wire logic INT_REQUEST,
   input wire logic [1:0] INT_PRIORITY,
   input wire logic [3:0] INT_SOURCE,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARREADY,
   input wire logic [AXI_DW-1:0] RDATA,
   input wire logic [1:0] RRESP,
   input wire logic RVALID,
   input wire logic RREADY
);
   logic quiet;
   // No source line high, so no pending bit can be set again
   assign quiet = PA_REQ == 8'h00 && PC_REQ == 4'h0 && !CMP_REQ;
   default clocking dc @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);
   // ----
   // Assertions
   // ----
   AST_LEVEL: assert property (INT_REQUEST |-> INT_PRIORITY != 2'h0)
      else $error("request shown at level zero");
   AST_SRC: assert property (INT_REQUEST |-> INT_SOURCE < 4'hc)
      else $error("source number out of range");
   AST_ACK: assert property (INT_ACK && INT_REQUEST && quiet ##1
      !INT_ACK && quiet |=> !INT_REQUEST || INT_SOURCE != $past(INT_SOURCE, 2))
      else $error("taken source still shown");
   AST_BHOLD: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write answer dropped");
   AST_RHOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read answer changed");
   AST_RHI: assert property (RVALID |-> RDATA[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_RERR: assert property (RVALID && RRESP != RESP_OKAY |-> RDATA == 0)
      else $error("error read not zero");
   AST_ARBLK: assert property (RVALID |-> !ARREADY)
      else $error("address taken during answer");
   COV_ACK: cover property (INT_ACK && INT_REQUEST);
   COV_B: cover property (BVALID && BREADY);
   COV_ERR: cover property (RVALID && RRESP == RESP_SLVERR);
endmodule

// *** verif/core_model.sv ***
// Core model that takes forwarded interrupts
`timescale 1ns/10ps
module core_model
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic req,
   input wire logic slow,
   output logic ack_q
);
   logic [2:0] wait_q;
   logic go;
   // Gap after each ack, as the shown source lags the pending bits
   assign go = req && wait_q == (slow ? 3'h6 : 3'h2);
   // ----
   // Acknowledge
   // ----
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wait_q <= 3'h0;
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= go;
         wait_q <= (req && !go) ? wait_q + 3'h1 : 3'h0;
      end
   end
endmodule

// *** verif/tb_port_interrupt_pending_priority.sv ***
// Testbench of the port interrupt block
`timescale 1ns/10ps
module tb_port_interrupt_pending_priority
   import pipp_pkg::*;
();
   typedef struct {logic [15:0] a; logic [7:0] d, e; logic [1:0] r;} row_t;
   logic sys_clk = 0, rstn = 0, cmp_req = 0, awvalid = 0, wvalid = 0;
   logic bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid;
   logic arready, rvalid, int_ack, int_request, slow = 0;
   logic [7:0] pa_req = 0;
   logic [3:0] pc_req = 0, int_source;
   logic [1:0] int_priority, bresp, rresp, resp, c;
   logic [15:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   int err_total = 0, total_checks = 0, cyc = 0;
   row_t rows[6] = '{'{ADDR_PRI_HI, 8'hff, 8'hff, RESP_OKAY},
      '{ADDR_PRI_LO, 8'h0f, 8'h0f, RESP_OKAY},
      '{ADDR_CTRL, 8'h02, 8'h02, RESP_OKAY},
      '{ADDR_PC_PEND, 8'h0f, 8'h0f, RESP_OKAY},
      '{ADDR_PA_PEND, 8'h5a, 8'h5a, RESP_OKAY},
      '{16'h0100, 8'h77, 8'h00, RESP_SLVERR}};
   port_interrupt_pending_priority DUT (.SYS_CLK(sys_clk), .RSTN(rstn),
      .PA_REQ(pa_req), .CMP_REQ(cmp_req), .PC_REQ(pc_req), .INT_ACK(int_ack),
      .INT_REQUEST(int_request), .INT_PRIORITY(int_priority),
      .INT_SOURCE(int_source), .AWADDR(awaddr), .AWPROT(3'h0),
      .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
      .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
      .RREADY(rready));
   core_model CORE (.clk(sys_clk), .rstn(rstn), .req(int_request),
      .slow(slow), .ack_q(int_ack));
   // Clock and a hang guard well past the expected run
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_total++;
         test_done();
      end
   end
   // ----
   // Tasks
   // ----
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      bit k;
      k = 0;
      @(posedge sys_clk);
      {awaddr, wdata} <= {a, 24'h0, d};
      {awvalid, wvalid, bready} <= 3'h7;
      while (!k)
      begin
         @(posedge sys_clk);
         if (awready)
            awvalid <= 0;
         if (wready)
            wvalid <= 0;
         if (bvalid)
         begin
            resp = bresp;
            bready <= 0;
            k = 1;
         end
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      bit k;
      k = 0;
      @(posedge sys_clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      while (!k)
      begin
         @(posedge sys_clk);
         if (arready)
            arvalid <= 0;
         if (rvalid)
         begin
            chk(rdata, {24'h0, e});
            resp = rresp;
            rready <= 0;
            k = 1;
         end
      end
   endtask
   task automatic pulse(input logic [7:0] a, input logic [3:0] p, logic m);
      @(posedge sys_clk);
      {pa_req, pc_req, cmp_req} <= {a, p, m};
      @(posedge sys_clk);
      {pa_req, pc_req, cmp_req} <= 13'h0;
   endtask
   // Waits a bounded time for the request line to reach a level
   task automatic wint(input logic v);
      for (int n = 0; n < 12 && int_request !== v; n++)
         @(negedge sys_clk);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ----
   // Sequence
   // ----
   initial
   begin
      repeat (10) @(posedge sys_clk);
      rstn <= 1;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         chk(resp, rows[i].r);
         rd(rows[i].a, rows[i].e);
         chk(resp, rows[i].r);
      end
      $display("register rows done");
      wr(ADDR_PA_PEND, 8'h00);
      wr(ADDR_PC_PEND, 8'h00);
      pulse(8'ha5, 4'h9, 0);
      wint(1);
      chk(int_request, 0);
      rd(ADDR_PA_PEND, 8'ha5);
      rd(ADDR_PC_PEND, 8'h09);
      pulse(8'h40, 4'h0, 0);
      rd(ADDR_PA_PEND, 8'ha5);
      pulse(8'h00, 4'h0, 1);
      rd(ADDR_PA_PEND, 8'he5);
      wr(ADDR_PA_PEND, 8'h00);
      wr(ADDR_PC_PEND, 8'h00);
      $display("polled test done");
      wr(ADDR_CTRL, 8'h01);
      for (int i = 0; i < 4; i++)
      begin
         c = i[1:0];
         slow <= c[0];
         wr(ADDR_PRI_HI, {5'h0, c[1], 2'h0});
         wr(ADDR_PRI_LO, {5'h0, c[0], 2'h0});
         pulse(8'h04, 4'h0, 0);
         wint(c != 0);
         chk(int_request, c != 0);
         chk(int_priority, c);
         if (c != 0)
            chk(int_source, 4'h2);
         wint(0);
         chk(int_request, 0);
         rd(ADDR_PA_PEND, c == 0 ? 8'h04 : 8'h00);
         wr(ADDR_PA_PEND, 8'h00);
      end
      pulse(8'h00, 4'h8, 0);
      wint(1);
      chk(int_source, 4'hb);
      chk(int_priority, PC_FIXED_PRI);
      $display("priority test done");
      wr(ADDR_CTRL, 8'h00);
      pulse(8'hff, 4'hf, 0);
      rd(ADDR_PA_PEND, 8'hff);
      rstn <= 0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1;
      rd(ADDR_PA_PEND, 8'h00);
      rd(ADDR_PC_PEND, 8'h00);
      $display("reset test done");
      test_done();
   end
endmodule
bind port_interrupt_pending_priority pipp_sva SVA (.SYS_CLK(SYS_CLK),
   .RSTN(RSTN), .PA_REQ(PA_REQ), .CMP_REQ(CMP_REQ), .PC_REQ(PC_REQ),
   .INT_ACK(INT_ACK), .INT_REQUEST(INT_REQUEST),
   .INT_PRIORITY(INT_PRIORITY), .INT_SOURCE(INT_SOURCE), .BVALID(BVALID),
   .BREADY(BREADY), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
   .RVALID(RVALID), .RREADY(RREADY));
